// ==== hw/axis_counter_pkg.sv ====
package axis_counter_pkg;

   // Register bus geometry: address = {axis, register}
   localparam int DATA_W     = 32;
   localparam int ADDR_W     = 6;
   localparam int AXIS_SHIFT = 3;
   localparam int AXIS_W     = ADDR_W - AXIS_SHIFT;

   // Counter width and modes
   localparam int CNT_W      = 28;
   localparam int HOME_MODES = 13;

   // Register indices inside one axis window
   localparam logic [AXIS_SHIFT-1:0] REG_CMD_POS  = 3'h0;
   localparam logic [AXIS_SHIFT-1:0] REG_FB_POS   = 3'h1;
   localparam logic [AXIS_SHIFT-1:0] REG_ERR_POS  = 3'h2;
   localparam logic [AXIS_SHIFT-1:0] REG_GP_CNT   = 3'h3;
   localparam logic [AXIS_SHIFT-1:0] REG_FB_CFG   = 3'h4;
   localparam logic [AXIS_SHIFT-1:0] REG_GP_CFG   = 3'h5;
   localparam logic [AXIS_SHIFT-1:0] REG_HOME_CFG = 3'h6;
   localparam logic [AXIS_SHIFT-1:0] REG_STATUS   = 3'h7;

   // Field positions
   localparam int FB_QUAD_BIT        = 0;
   localparam int FB_MULT_LSB        = 1;
   localparam int FB_SRC_BIT         = 3;
   localparam int GP_SRC_LSB         = 0;
   localparam int HOME_MODE_LSB      = 0;
   localparam int ORIGIN_POL_BIT     = 4;
   localparam int ORIGIN_LATCH_BIT   = 5;
   localparam int IDX_POL_BIT        = 6;
   localparam int ST_IDX_BIT         = 0;
   localparam int ST_ORIGIN_LVL_BIT  = 1;
   localparam int ST_ORIGIN_HELD_BIT = 2;

   // Step encoding of one count event
   localparam logic [1:0] STEP_NONE = 2'h0;
   localparam logic [1:0] STEP_UP   = 2'h1;
   localparam logic [1:0] STEP_DN   = 2'h3;

   typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4} mult_t;
   typedef enum logic [1:0] {GP_OUT, GP_FB, GP_PULSER, GP_TIMER} gp_src_t;

   // Reset values
   localparam mult_t      FB_MULT_RST   = MULT_X1;
   localparam gp_src_t    GP_SRC_RST    = GP_PULSER;
   localparam logic [3:0] HOME_MODE_RST = 4'h0;

   // Pins of one axis, all asynchronous to clk_in
   typedef struct packed {
      logic encoder_phase_first;
      logic encoder_phase_second;
      logic encoder_index_input;
      logic origin_input;
      logic pulser_a;
      logic pulser_b;
   } axis_pins_t;

   // Pulse generator status of one axis, same clock domain
   typedef struct packed {
      logic pulse;
      logic dir_plus;
      logic home_done;
   } motion_t;

endpackage

// ==== hw/axis_position_counters.sv ====
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module axis_position_counters
   import axis_counter_pkg::*;
#(
   parameter int NUM_AXES = 4
)
(
   input  wire logic                      clk_in,
   input  wire logic                      nrst_in,
   input  wire logic                      ce_in,
   input  wire logic [ADDR_W-1:0]         addr_in,
   input  wire logic [DATA_W-1:0]         wr_data_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [DATA_W-1:0]         rd_data_out,
   input  wire axis_pins_t [NUM_AXES-1:0] pins_in,
   input  wire motion_t    [NUM_AXES-1:0] motion_in,
   output logic      [NUM_AXES-1:0]       origin_active_out,
   output logic      [NUM_AXES-1:0]       index_active_out,
   output logic      [NUM_AXES-1:0][3:0]  home_mode_out
);

   // Sync chains: bit 0 first stage, bit 1 second stage, bit 2 previous value
   typedef struct packed {
      logic [CNT_W-1:0] cmd;
      logic [CNT_W-1:0] fb;
      logic [CNT_W-1:0] err;
      logic [CNT_W-1:0] gp;
      logic             fb_quad;
      mult_t            fb_mult;
      logic             fb_src;
      gp_src_t          gp_src;
      logic [3:0]       home_mode;
      logic             origin_pol;
      logic             origin_latch_en;
      logic             idx_pol;
      logic             origin_held;
      logic             origin_act;
      logic             idx_act;
      logic             tick;
      logic [1:0]       warm;
      logic [2:0]       s_a;
      logic [2:0]       s_b;
      logic [2:0]       s_z;
      logic [2:0]       s_o;
      logic [2:0]       s_pa;
      logic [2:0]       s_pb;
   } axis_t;
   typedef struct packed {
      axis_t [NUM_AXES-1:0] ax;
      logic  [DATA_W-1:0]   rd_data;
   } state_t;
   state_t st_r;
   state_t st_nxt;
   // Wraps silently: no overflow flag exists on purpose
   function automatic logic [CNT_W-1:0] add_step(input logic [CNT_W-1:0] cnt, input logic [1:0] step);
      add_step = cnt;
      if (step == STEP_UP)
      begin
         add_step = cnt + CNT_W'(1);
      end
      else if (step == STEP_DN)
      begin
         add_step = cnt - CNT_W'(1);
      end
   endfunction
   function automatic logic [1:0] neg_step(input logic [1:0] step);
      neg_step = STEP_NONE;
      if (step == STEP_UP)
      begin
         neg_step = STEP_DN;
      end
      else if (step == STEP_DN)
      begin
         neg_step = STEP_UP;
      end
   endfunction
   // Illegal double changes are dropped, not guessed
   function automatic logic [1:0] quad_step(input logic a, input logic b, input logic pa,
                                            input logic pb, input mult_t m);
      logic ca;
      logic cb;
      ca = a ^ pa;
      cb = b ^ pb;
      quad_step = STEP_NONE;
      case (m)
         MULT_X1:
         begin
            if (ca && !cb && a)
            begin
               quad_step = b ? STEP_DN : STEP_UP;
            end
         end
         MULT_X2:
         begin
            if (ca && !cb)
            begin
               quad_step = (a ^ b) ? STEP_UP : STEP_DN;
            end
         end
         default:
         begin
            if (ca ^ cb)
            begin
               quad_step = (a ^ pb) ? STEP_UP : STEP_DN;
            end
         end
      endcase
   endfunction
   function automatic logic [DATA_W-1:0] zext(input logic [CNT_W-1:0] v);
      zext = {{(DATA_W-CNT_W){1'b0}}, v};
   endfunction

   always_comb
   begin
      axis_t      cur;
      axis_t      a;
      logic [1:0] cmd_step;
      logic [1:0] enc_step;
      logic [1:0] fb_step;
      logic [1:0] gp_step;
      logic [1:0] pls_step;
      logic       origin_lvl;
      logic       sel;
      logic [AXIS_SHIFT-1:0] r;
      st_nxt   = st_r;
      cur      = '0;
      a        = '0;
      cmd_step = STEP_NONE;
      enc_step = STEP_NONE;
      fb_step  = STEP_NONE;
      gp_step  = STEP_NONE;
      pls_step = STEP_NONE;
      origin_lvl = 1'b0;
      sel      = 1'b0;
      r        = addr_in[AXIS_SHIFT-1:0];
      // Read data stands only in the cycle after the strobe
      st_nxt.rd_data = '0;
      for (int i = 0; i < NUM_AXES; i++)
      begin
         cur = st_r.ax[i];
         a   = cur;
         a.s_a  = {cur.s_a[1:0], pins_in[i].encoder_phase_first};
         a.s_b  = {cur.s_b[1:0], pins_in[i].encoder_phase_second};
         a.s_z  = {cur.s_z[1:0], pins_in[i].encoder_index_input};
         a.s_o  = {cur.s_o[1:0], pins_in[i].origin_input};
         a.s_pa = {cur.s_pa[1:0], pins_in[i].pulser_a};
         a.s_pb = {cur.s_pb[1:0], pins_in[i].pulser_b};
         a.tick = ~cur.tick;
         a.warm = cur.warm + {1'b0, cur.warm != 2'h3};
         cmd_step = motion_in[i].pulse ? (motion_in[i].dir_plus ? STEP_UP : STEP_DN) : STEP_NONE;
         if (cur.fb_quad)
         begin
            enc_step = quad_step(cur.s_a[1], cur.s_b[1], cur.s_a[2], cur.s_b[2], cur.fb_mult);
         end
         else if (cur.s_a[1] && !cur.s_a[2] && !(cur.s_b[1] && !cur.s_b[2]))
         begin
            enc_step = STEP_UP;
         end
         else if (cur.s_b[1] && !cur.s_b[2] && !(cur.s_a[1] && !cur.s_a[2]))
         begin
            enc_step = STEP_DN;
         end
         else
         begin
            enc_step = STEP_NONE;
         end
         pls_step = quad_step(cur.s_pa[1], cur.s_pb[1], cur.s_pa[2], cur.s_pb[2], MULT_X1);
         // Chains hold reset zeros for three edges; a pin idling high would fake an edge
         if (cur.warm != 2'h3)
         begin
            enc_step = STEP_NONE;
            pls_step = STEP_NONE;
         end
         // Mode select steers the decoder above; source select
         fb_step  = cur.fb_src ? cmd_step : enc_step;
         case (cur.gp_src)
            GP_OUT:    gp_step = cmd_step;
            GP_FB:     gp_step = fb_step;
            GP_PULSER: gp_step = pls_step;
            default:   gp_step = cur.tick ? STEP_UP : STEP_NONE;
         endcase
         a.cmd = add_step(cur.cmd, cmd_step);
         a.fb  = add_step(cur.fb, fb_step);
         a.err = add_step(add_step(cur.err, cmd_step), neg_step(enc_step));
         a.gp  = add_step(cur.gp, gp_step);
         a.idx_act = cur.s_z[1] ^ cur.idx_pol;
         origin_lvl = cur.s_o[1] ^ cur.origin_pol;
         if (motion_in[i].home_done)
         begin
            a.cmd = '0;
            a.fb  = '0;
            a.err = '0;
         end
         sel = (addr_in[ADDR_W-1:AXIS_SHIFT] == AXIS_W'(i));
         // Host write wins over counting and home clear in the same cycle
         if (wr_in && sel)
         begin
            if (r == REG_CMD_POS)
            begin
               a.cmd = wr_data_in[CNT_W-1:0];
            end
            else if (r == REG_FB_POS)
            begin
               a.fb = wr_data_in[CNT_W-1:0];
            end
            else if (r == REG_ERR_POS)
            begin
               a.err = '0;
            end
            else if (r == REG_GP_CNT)
            begin
               a.gp = wr_data_in[CNT_W-1:0];
            end
            else if (r == REG_FB_CFG)
            begin
               a.fb_quad = wr_data_in[FB_QUAD_BIT];
               a.fb_src  = wr_data_in[FB_SRC_BIT];
               if (wr_data_in[FB_MULT_LSB+:2] <= 2'(MULT_X4))
               begin
                  a.fb_mult = mult_t'(wr_data_in[FB_MULT_LSB+:2]);
               end
            end
            else if (r == REG_GP_CFG)
            begin
               a.gp_src = gp_src_t'(wr_data_in[GP_SRC_LSB+:2]);
            end
            else if (r == REG_HOME_CFG)
            begin
               // Only the thirteen defined modes are kept
               if (wr_data_in[HOME_MODE_LSB+:4] < 4'(HOME_MODES))
               begin
                  a.home_mode = wr_data_in[HOME_MODE_LSB+:4];
               end
               a.origin_pol      = wr_data_in[ORIGIN_POL_BIT];
               a.origin_latch_en = wr_data_in[ORIGIN_LATCH_BIT];
               a.idx_pol         = wr_data_in[IDX_POL_BIT];
            end
            else if (r == REG_STATUS)
            begin
               if (wr_data_in[ST_ORIGIN_HELD_BIT])
               begin
                  a.origin_held = 1'b0;
               end
            end
         end
         // Latched capture; an active origin level beats a clear
         if (origin_lvl)
         begin
            a.origin_held = 1'b1;
         end
         a.origin_act = cur.origin_latch_en ? (cur.origin_held | origin_lvl) : origin_lvl;
         if (rd_in && sel)
         begin
            if (r == REG_CMD_POS)
            begin
               st_nxt.rd_data = zext(cur.cmd);
            end
            else if (r == REG_FB_POS)
            begin
               st_nxt.rd_data = zext(cur.fb);
            end
            else if (r == REG_ERR_POS)
            begin
               st_nxt.rd_data = zext(cur.err);
            end
            else if (r == REG_GP_CNT)
            begin
               st_nxt.rd_data = zext(cur.gp);
            end
            else if (r == REG_FB_CFG)
            begin
               st_nxt.rd_data[FB_QUAD_BIT]    = cur.fb_quad;
               st_nxt.rd_data[FB_MULT_LSB+:2] = cur.fb_mult;
               st_nxt.rd_data[FB_SRC_BIT]     = cur.fb_src;
            end
            else if (r == REG_GP_CFG)
            begin
               st_nxt.rd_data[GP_SRC_LSB+:2] = cur.gp_src;
            end
            else if (r == REG_HOME_CFG)
            begin
               st_nxt.rd_data[HOME_MODE_LSB+:4] = cur.home_mode;
               st_nxt.rd_data[ORIGIN_POL_BIT]   = cur.origin_pol;
               st_nxt.rd_data[ORIGIN_LATCH_BIT] = cur.origin_latch_en;
               st_nxt.rd_data[IDX_POL_BIT]      = cur.idx_pol;
            end
            else
            begin
               st_nxt.rd_data[ST_IDX_BIT]         = cur.idx_act;
               st_nxt.rd_data[ST_ORIGIN_LVL_BIT]  = cur.origin_act;
               st_nxt.rd_data[ST_ORIGIN_HELD_BIT] = cur.origin_held;
            end
         end
         st_nxt.ax[i] = a;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_r <= '0;
         for (int i = 0; i < NUM_AXES; i++)
         begin
            st_r.ax[i].fb_mult   <= FB_MULT_RST;
            st_r.ax[i].gp_src    <= GP_SRC_RST;
            st_r.ax[i].home_mode <= HOME_MODE_RST;
         end
      end
      else if (ce_in)
      begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_out = st_r.rd_data;

   for (genvar g = 0; g < NUM_AXES; g++)
   begin : g_out
      assign origin_active_out[g] = st_r.ax[g].origin_act;
      assign index_active_out[g]  = st_r.ax[g].idx_act;
      // Homing sequencer reads the mode the host set beforehand
      assign home_mode_out[g]     = st_r.ax[g].home_mode;
   end

endmodule

// ==== verification/axis_counters_sva.sv ====
`timescale 1ns/1ps
module axis_counters_sva
   import axis_counter_pkg::*;
#(
   parameter int NUM_AXES = 4
)
(
   input wire logic                      clk_in,
   input wire logic                      nrst_in,
   input wire logic                      ce_in,
   input wire logic [ADDR_W-1:0]         addr_in,
   input wire logic [DATA_W-1:0]         wr_data_in,
   input wire logic                      wr_in,
   input wire logic                      rd_in,
   input wire logic [DATA_W-1:0]         rd_data_out,
   input wire axis_pins_t [NUM_AXES-1:0] pins_in,
   input wire motion_t    [NUM_AXES-1:0] motion_in,
   input wire logic [NUM_AXES-1:0]       origin_active_out,
   input wire logic [NUM_AXES-1:0]       index_active_out,
   input wire logic [NUM_AXES-1:0][3:0]  home_mode_out
);
   logic mode_ok;
   // Every axis must hold a legal mode, not only the one under test
   always_comb
   begin
      mode_ok = 1'b1;
      for (int i = 0; i < NUM_AXES; i++)
         mode_ok = mode_ok & (home_mode_out[i] < 4'(HOME_MODES));
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   property p_rd_idle;
      ce_in && !rd_in |=> rd_data_out == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_hi_zero;
      ce_in && rd_in && addr_in[5:3] < NUM_AXES && addr_in[2:0] < REG_FB_CFG |=> rd_data_out[31:28] == 4'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("counter upper bits not zero");
   property p_unmapped;
      ce_in && rd_in && addr_in[5:3] >= NUM_AXES |=> rd_data_out == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped axis read not zero");
   property p_mode_range;
      mode_ok;
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("home mode out of range");
   property p_mode_hold;
      $changed(home_mode_out) |-> $past(wr_in && ce_in && addr_in[2:0] == REG_HOME_CFG);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("home mode changed without write");
   property p_mode_set;
      ce_in && wr_in && addr_in == {3'h0, REG_HOME_CFG} && wr_data_in[3:0] < 4'(HOME_MODES)
         |=> home_mode_out[0] == $past(wr_data_in[3:0]);
   endproperty
   a_mode_set: assert property (p_mode_set) else $error("home mode write lost");
   property p_mode_refuse;
      ce_in && wr_in && addr_in == {3'h0, REG_HOME_CFG} && wr_data_in[3:0] >= 4'(HOME_MODES)
         |=> $stable(home_mode_out[0]);
   endproperty
   a_mode_refuse: assert property (p_mode_refuse) else $error("illegal home mode taken");
   property p_freeze;
      !ce_in |=> $stable(rd_data_out) && $stable(origin_active_out) && $stable(index_active_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
endmodule
bind axis_position_counters axis_counters_sva #(.NUM_AXES(NUM_AXES)) u_sva (
   .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .pins_in(pins_in), .motion_in(motion_in),
   .origin_active_out(origin_active_out), .index_active_out(index_active_out),
   .home_mode_out(home_mode_out));

// ==== verification/encoder_model.sv ====
`timescale 1ns/1ps
module encoder_model
   import axis_counter_pkg::*;
(
   input  wire logic clk_in,
   output axis_pins_t pins_out
);
   logic [1:0] q_r      = 2'h0;
   logic       quad_r   = 1'b0;
   logic       up_r     = 1'b0;
   logic       dn_r     = 1'b0;
   logic       origin_r = 1'b0;
   logic       idx_r    = 1'b0;
   logic       ph_a;
   logic       ph_b;
   // Gray order, first phase leads forward
   assign ph_a = q_r[0] ^ q_r[1];
   assign ph_b = q_r[1];
   assign pins_out = '{encoder_phase_first: quad_r ? ph_a : up_r, encoder_phase_second: quad_r ? ph_b : dn_r,
                       encoder_index_input: idx_r, origin_input: origin_r, pulser_a: ph_a, pulser_b: ph_b};
   // Each level held at least 4 clocks, longer than the 2-flop synchroniser
   task automatic step(input logic quad, input logic fwd, input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         quad_r <= quad;
         if (quad)
            q_r <= fwd ? q_r + 2'h1 : q_r - 2'h1;
         else if (fwd)
            up_r <= 1'b1;
         else
            dn_r <= 1'b1;
         repeat (4) @(posedge clk_in);
         up_r <= 1'b0;
         dn_r <= 1'b0;
         repeat (4) @(posedge clk_in);
      end
   endtask
   task automatic level(input logic origin_lvl, input logic idx);
      @(posedge clk_in);
      origin_r <= origin_lvl;
      idx_r <= idx;
      repeat (6) @(posedge clk_in);
      // Step off the edge so callers read settled outputs
      #1;
   endtask
endmodule

// ==== verification/tb_axis_position_counters.sv ====
`timescale 1ns/1ps
module tb_axis_position_counters;
   import axis_counter_pkg::*;
   localparam int NA = 2;
   logic                 clk_in  = 1'b0;
   logic                 nrst_in = 1'b0;
   logic                 ce_in   = 1'b1;
   logic [ADDR_W-1:0]    addr    = '0;
   logic [DATA_W-1:0]    wdata   = '0;
   logic                 wr      = 1'b0;
   logic                 rd      = 1'b0;
   logic [DATA_W-1:0]    rd_data;
   axis_pins_t [NA-1:0]  pins;
   motion_t [NA-1:0]     mot     = '0;
   logic [NA-1:0]        origin_act;
   logic [NA-1:0]        idx_act;
   logic [NA-1:0][3:0]   hmode;
   logic [DATA_W-1:0]    v;
   int                   num_errors = 0;
   int                   num_checks = 0;
   int                   cyc        = 0;
   always #25 clk_in = ~clk_in;
   axis_position_counters #(.NUM_AXES(NA)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
      .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .pins_in(pins),
      .motion_in(mot), .origin_active_out(origin_act), .index_active_out(idx_act), .home_mode_out(hmode));
   encoder_model enc0 (.clk_in(clk_in), .pins_out(pins[0]));
   encoder_model enc1 (.clk_in(clk_in), .pins_out(pins[1]));
   function automatic logic [5:0] ad(input int ax, input logic [2:0] r);
      return {3'(ax), r};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      v = rd_data;
      check($sformatf("reg %h", a), v, exp);
   endtask
   task automatic pulse(input logic up);
      @(posedge clk_in);
      mot[0].pulse <= 1'b1;
      mot[0].dir_plus <= up;
      @(posedge clk_in);
      mot[0].pulse <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Whole run needs about 570 cycles
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      ce_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      ce_in <= 1'b1;
      rc(ad(0, REG_GP_CFG), 32'h2);
      rc(ad(0, REG_FB_CFG), 32'h0);
      rc(ad(1, REG_CMD_POS), 32'h0);
      rc(ad(2, REG_CMD_POS), 32'h0);
      $display("test done: reset");
      for (int m = 0; m < 3; m++)
      begin
         wr_reg(ad(0, REG_FB_CFG), 32'(1 + 2 * m));
         wr_reg(ad(0, REG_FB_POS), 32'h0);
         enc0.step(1'b1, 1'b1, 8);
         rc(ad(0, REG_FB_POS), 32'(2 << m));
         enc0.step(1'b1, 1'b0, 4);
         rc(ad(0, REG_FB_POS), 32'(1 << m));
      end
      wr_reg(ad(0, REG_FB_CFG), 32'h7);
      rc(ad(0, REG_FB_CFG), 32'h5);
      rc(ad(0, REG_GP_CNT), 32'h3);
      $display("test done: quadrature");
      wr_reg(ad(0, REG_GP_CFG), 32'h0);
      wr_reg(ad(0, REG_GP_CNT), 32'h0);
      wr_reg(ad(0, REG_ERR_POS), 32'h5);
      rc(ad(0, REG_ERR_POS), 32'h0);
      wr_reg(ad(0, REG_CMD_POS), 32'h0FFFFFFF);
      pulse(1'b1);
      rc(ad(0, REG_CMD_POS), 32'h0);
      rc(ad(0, REG_GP_CNT), 32'h1);
      repeat (3) pulse(1'b0);
      rc(ad(0, REG_CMD_POS), 32'h0FFFFFFD);
      rc(ad(0, REG_ERR_POS), 32'h0FFFFFFE);
      wr_reg(ad(0, REG_FB_CFG), 32'h8);
      wr_reg(ad(0, REG_FB_POS), 32'h0);
      repeat (2) pulse(1'b1);
      rc(ad(0, REG_FB_POS), 32'h2);
      $display("test done: command");
      wr_reg(ad(0, REG_FB_CFG), 32'h0);
      wr_reg(ad(0, REG_FB_POS), 32'h0);
      wr_reg(ad(0, REG_ERR_POS), 32'h0);
      wr_reg(ad(0, REG_GP_CFG), 32'h1);
      wr_reg(ad(0, REG_GP_CNT), 32'h100);
      enc0.step(1'b0, 1'b1, 3);
      enc0.step(1'b0, 1'b0, 1);
      rc(ad(0, REG_FB_POS), 32'h2);
      rc(ad(0, REG_ERR_POS), 32'h0FFFFFFE);
      rc(ad(0, REG_GP_CNT), 32'h102);
      rc(ad(1, REG_FB_POS), 32'h0);
      $display("test done: up down");
      wr_reg(ad(0, REG_HOME_CFG), 32'h3);
      @(posedge clk_in);
      mot[0].home_done <= 1'b1;
      @(posedge clk_in);
      mot[0].home_done <= 1'b0;
      rc(ad(0, REG_CMD_POS), 32'h0);
      rc(ad(0, REG_FB_POS), 32'h0);
      rc(ad(0, REG_ERR_POS), 32'h0);
      $display("test done: home clear");
      wr_reg(ad(0, REG_HOME_CFG), 32'h20);
      enc0.level(1'b1, 1'b1);
      check("index", 32'(idx_act[0]), 32'h1);
      rc(ad(0, REG_STATUS), 32'h7);
      enc0.level(1'b0, 1'b0);
      check("origin held", 32'(origin_act[0]), 32'h1);
      wr_reg(ad(0, REG_STATUS), 32'h4);
      enc0.level(1'b0, 1'b0);
      check("origin cleared", 32'(origin_act[0]), 32'h0);
      wr_reg(ad(0, REG_HOME_CFG), 32'h50);
      rc(ad(0, REG_HOME_CFG), 32'h50);
      enc0.level(1'b0, 1'b0);
      check("origin low", 32'(origin_act[0]), 32'h1);
      check("index low", 32'(idx_act[0]), 32'h1);
      wr_reg(ad(0, REG_HOME_CFG), 32'hC);
      #1;
      check("mode", 32'(hmode[0]), 32'hC);
      wr_reg(ad(0, REG_HOME_CFG), 32'hD);
      #1;
      check("mode kept", 32'(hmode[0]), 32'hC);
      $display("test done: homing");
      wr_reg(ad(0, REG_GP_CFG), 32'h3);
      wr_reg(ad(0, REG_GP_CNT), 32'h0);
      // An even number of edges makes the half-rate count phase-free
      repeat (39) @(posedge clk_in);
      rc(ad(0, REG_GP_CNT), 32'h14);
      rc(ad(0, REG_GP_CNT), 32'h15);
      $display("test done: timer");
      give_verdict();
   end
endmodule
